// [fieldbus_command_monitor_port.v]
// device-side command/monitor exchange for a cyclic fieldbus slave, with
// an apb register slave and one level interrupt.
// assumes all fieldbus inputs are synchronous to clk, already link-scanned.
`timescale 1ns/1ps
`include "fcmp_defs.vh"

module fieldbus_command_monitor_port #(
  parameter [`LAG_CNT_W-1:0] ECHO_LAG_CYCLES = `ECHO_LAG_MS * `CLK_KHZ
) (
  input wire clk,
  input wire srst,
  input wire [3:0] mode_select_in,
  input wire cmd_request,
  input wire [255:0] command_words,
  output wire [255:0] reply_words,
  output wire cmd_finish,
  output wire cmd_error,
  output wire [3:0] mode_select_echo,
  input wire [127:0] position_in,
  input wire [15:0] torque_in,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq
);

// handshake states
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_EXEC = 3'b010;
localparam [2:0] S_DONE = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [255:0] reply_r;
reg [255:0] reply_nxt;
reg finish_r;
reg error_r;
reg fail_nxt;
reg [15:0] cnt_mem_r [0:15];
reg cnt_we;
reg [15:0] override_r;
reg [15:0] last_cmd_r;
reg busy_r;
reg [15:0] status_val_r;
reg [`INT_W-1:0] int_stat_r;
reg [`INT_W-1:0] int_en_r;
reg [31:0] prdata_r;
reg pslverr_r;
reg [3:0] echo_last_r;
wire [3:0] echo_w;
wire cmd_mode;
wire apb_setup;
wire apb_wr;
wire [`INT_W-1:0] int_evt;
wire [`INT_W-1:0] int_clr;
integer i;
integer j;

// one 16-bit word out of a flat 16-word bus
function [15:0] word_of;
  input [255:0] bus;
  input [3:0] idx;
  begin
    word_of = bus[idx*`WORD_W +: `WORD_W];
  end
endfunction

// true when the apb address names a given register
function hit;
  input [7:0] addr;
  input [7:0] reg_addr;
  begin
    hit = (addr == reg_addr);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// mode echo with its settling lag
// lagged echo copy
mode_echo_lag #(
  .LAG_CYCLES(ECHO_LAG_CYCLES)
) u_echo (
  .clk(clk),
  .srst(srst),
  .mode_in(mode_select_in),
  .mode_echo_r(echo_w)
);
assign mode_select_echo = echo_w;

assign cmd_mode = (mode_select_in == `MODE_CMD);

////////////////////////////////////////////////////////////////////////
// reply builder: command processing in command mode, live data otherwise
always @* begin
  reply_nxt = reply_r;
  fail_nxt = 1'b0;
  cnt_we = 1'b0;
  i = 0;
  if (!cmd_mode) begin
    reply_nxt = 256'h0;
    case (mode_select_in)
      `MODE_STATUS: begin
        reply_nxt[`W_CODE*`WORD_W +: `WORD_W] = status_val_r;
      end
      `MODE_POS: begin
        reply_nxt[`W_DATA*`WORD_W +: 128] = position_in;
      end
      `MODE_COUNT: begin
        reply_nxt[`W_CODE*`WORD_W +: `WORD_W] = word_of(command_words,
          `W_CODE);
        reply_nxt[`W_ARG1*`WORD_W +: `WORD_W] = word_of(command_words,
          `W_ARG1);
        if (word_of(command_words, `W_CODE) == `SUB_ARBITRARY) begin
          reply_nxt[`W_ARG2*`WORD_W +: `WORD_W] =
            cnt_mem_r[command_words[`W_ARG1*`WORD_W +: 4]];
        end else if (word_of(command_words, `W_CODE) == `SUB_SEQUENCE) begin
          // consecutive counters from the designated number onward
          for (i = 0; i < 14; i = i + 1) begin
            reply_nxt[(i+2)*`WORD_W +: `WORD_W] = cnt_mem_r[
              command_words[`W_ARG1*`WORD_W +: 4] + i[3:0]];
          end
        end else begin
          reply_nxt[`W_ERR*`WORD_W +: `WORD_W] = `ERR_ANALYSIS;
        end
      end
      `MODE_TORQUE: begin
        reply_nxt[`W_DATA*`WORD_W +: `WORD_W] = torque_in;
      end
      default: begin
        // reserved codes: replies stay zero
        reply_nxt = 256'h0;
      end
    endcase
  end else if (state_r == S_EXEC) begin
    reply_nxt = 256'h0;
    reply_nxt[`W_CODE*`WORD_W +: `WORD_W] = word_of(command_words,
      `W_CODE);
    reply_nxt[`W_ARG1*`WORD_W +: `WORD_W] = word_of(command_words,
      `W_ARG1);
    if (busy_r) begin
      fail_nxt = 1'b1;
      reply_nxt[`W_ERR*`WORD_W +: `WORD_W] = `ERR_BUSY;
    end else begin
      case (word_of(command_words, `W_CODE))
        `CMD_STATUS: begin
          reply_nxt[`W_ARG2*`WORD_W +: `WORD_W] = status_val_r;
        end
        `CMD_POSITION: begin
          reply_nxt[`W_DATA*`WORD_W +: 128] = position_in;
        end
        `CMD_COUNT_RD: begin
          reply_nxt[`W_ARG2*`WORD_W +: `WORD_W] =
            cnt_mem_r[command_words[`W_ARG1*`WORD_W +: 4]];
        end
        `CMD_COUNT_WR: begin
          cnt_we = 1'b1;
        end
        `CMD_OVR_WR: begin
          reply_nxt[`W_ARG1*`WORD_W +: `WORD_W] = word_of(command_words,
            `W_ARG1);
        end
        `CMD_OVR_RD: begin
          reply_nxt[`W_ARG1*`WORD_W +: `WORD_W] = override_r;
        end
        `CMD_TORQUE: begin
          reply_nxt[`W_ARG1*`WORD_W +: `WORD_W] = 16'h0000;
          reply_nxt[`W_DATA*`WORD_W +: `WORD_W] = torque_in;
        end
        default: begin
          fail_nxt = 1'b1;
          reply_nxt[`W_ERR*`WORD_W +: `WORD_W] = `ERR_ANALYSIS;
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// handshake sequencer
always @* begin
  state_nxt = state_r;
  case (state_r)
    S_IDLE: begin
      if (cmd_mode && cmd_request) begin
        state_nxt = S_EXEC;
      end
    end
    S_EXEC: begin
      state_nxt = cmd_mode ? S_DONE : S_IDLE;
    end
    S_DONE: begin
      if (!cmd_request || !cmd_mode) begin
        state_nxt = S_IDLE;
      end
    end
    default: begin
      state_nxt = S_IDLE;
    end
  endcase
end

always @(posedge clk) begin
  if (srst) begin
    state_r <= S_IDLE;
    reply_r <= 256'h0;
    finish_r <= 1'b0;
    error_r <= 1'b0;
    last_cmd_r <= 16'h0000;
    override_r <= 16'h0000;
  end else begin
    state_r <= state_nxt;
    reply_r <= reply_nxt;
    finish_r <= (state_nxt == S_DONE);
    error_r <= (state_nxt == S_DONE) &&
      ((state_r == S_EXEC) ? fail_nxt : error_r);
    if (state_r == S_EXEC) begin
      last_cmd_r <= word_of(command_words, `W_CODE);
      if (!busy_r && word_of(command_words, `W_CODE) == `CMD_OVR_WR) begin
        override_r <= word_of(command_words, `W_ARG1);
      end
    end
  end
end

// counter table written by the set-counter command
always @(posedge clk) begin
  if (srst) begin
    for (j = 0; j < `WORDS; j = j + 1) begin
      cnt_mem_r[j] <= 16'h0000;
    end
  end else if (cnt_we) begin
    cnt_mem_r[command_words[`W_ARG1*`WORD_W +: 4]] <=
      word_of(command_words, `W_ARG2);
  end
end

assign reply_words = reply_r;
assign cmd_finish = finish_r;
assign cmd_error = error_r;

////////////////////////////////////////////////////////////////////////
// interrupt events: done, error, echo change, reserved mode
assign int_evt[`INT_DONE] = (state_r == S_EXEC) && cmd_mode;
assign int_evt[`INT_ERR] = (state_r == S_EXEC) && cmd_mode && fail_nxt;
assign int_evt[`INT_MODE] = (echo_w != echo_last_r);
assign int_evt[`INT_RSVD] = (mode_select_in > `MODE_TORQUE);

assign apb_setup = psel && !penable;
assign apb_wr = psel && penable && pwrite;
assign int_clr = (apb_wr && hit(paddr, `A_INT_CLR)) ?
  pwdata[`INT_W-1:0] : {`INT_W{1'b0}};

// sticky status, a new event beats a clear in the same cycle
always @(posedge clk) begin
  if (srst) begin
    int_stat_r <= {`INT_W{1'b0}};
    echo_last_r <= `MODE_CMD;
  end else begin
    int_stat_r <= (int_stat_r & ~int_clr) | int_evt;
    echo_last_r <= echo_w;
  end
end

assign irq = |(int_stat_r & int_en_r);

////////////////////////////////////////////////////////////////////////
// apb slave: zero wait, read data captured in the setup cycle
always @(posedge clk) begin
  if (srst) begin
    busy_r <= 1'b0;
    status_val_r <= 16'h0000;
    int_en_r <= {`INT_W{1'b0}};
  end else if (apb_wr) begin
    if (hit(paddr, `A_CTRL)) begin
      busy_r <= pwdata[`CTRL_BUSY];
    end
    if (hit(paddr, `A_INT_EN)) begin
      int_en_r <= pwdata[`INT_W-1:0];
    end
    if (hit(paddr, `A_STATUS_VAL)) begin
      status_val_r <= pwdata[15:0];
    end
  end
end

// read mux registered so prdata comes from flops in the access phase
always @(posedge clk) begin
  if (srst) begin
    prdata_r <= 32'h0;
    pslverr_r <= 1'b0;
  end else if (apb_setup) begin
    pslverr_r <= 1'b0;
    case (paddr)
      `A_CTRL: prdata_r <= {31'h0, busy_r};
      `A_STATE: prdata_r <= {17'h0, state_r, echo_w, mode_select_in,
        2'b00, error_r, finish_r};
      `A_INT_STAT: prdata_r <= {28'h0, int_stat_r};
      `A_INT_CLR: prdata_r <= 32'h0;
      `A_INT_EN: prdata_r <= {28'h0, int_en_r};
      `A_STATUS_VAL: prdata_r <= {16'h0, status_val_r};
      `A_LAST_CMD: prdata_r <= {16'h0, last_cmd_r};
      default: begin
        prdata_r <= 32'h0;
        pslverr_r <= 1'b1; // unmapped
      end
    endcase
  end
end

assign prdata = prdata_r;
assign pready = 1'b1;
assign pslverr = pslverr_r && psel && penable;

endmodule

// [fcmp_defs.vh]
// constants for the fieldbus command/monitor port: mode codes, command
// codes, reply layout, error codes, timing and the apb register map.
// assumes inclusion by bare name from the design files.
`ifndef FCMP_DEFS_VH
`define FCMP_DEFS_VH

// mode-select codes
`define MODE_CMD 4'h0
`define MODE_STATUS 4'h1
`define MODE_POS 4'h2
`define MODE_COUNT 4'h3
`define MODE_TORQUE 4'h4

// counter monitor sub-modes, held in the first command word
`define SUB_ARBITRARY 16'h0000
`define SUB_SEQUENCE 16'h0001

// command codes in command word 0
`define CMD_STATUS 16'hb900
`define CMD_POSITION 16'he300
`define CMD_COUNT_RD 16'he500
`define CMD_COUNT_WR 16'he700
`define CMD_OVR_WR 16'hd900
`define CMD_OVR_RD 16'hda00
`define CMD_TORQUE 16'hee08

// reply error codes
`define ERR_NONE 16'h0000
`define ERR_ANALYSIS 16'h1000
`define ERR_BUSY 16'h2001

// reply word positions
`define W_CODE 4'h0
`define W_ARG1 4'h1
`define W_ARG2 4'h2
`define W_ERR 4'h3
`define W_DATA 4'h4
`define WORD_W 16
`define WORDS 16

// echo lag timing
// sized to the lag counter so their product needs no truncation
`define ECHO_LAG_MS 24'h00000a
`define CLK_KHZ 24'h0186a0
`define LAG_CNT_W 24

// apb register byte addresses
`define A_CTRL 8'h00
`define A_STATE 8'h04
`define A_INT_STAT 8'h08
`define A_INT_CLR 8'h0c
`define A_INT_EN 8'h10
`define A_STATUS_VAL 8'h14
`define A_LAST_CMD 8'h18

// ctrl bits
`define CTRL_BUSY 0
// interrupt bits
`define INT_DONE 0
`define INT_ERR 1
`define INT_MODE 2
`define INT_RSVD 3
`define INT_W 4

`endif

// [mode_echo_lag.v]
// mode-select echo with a settling lag: the echo copies the input only
// after the input has stood unchanged for the whole lag count.
// assumes the input is synchronous to clk.
`timescale 1ns/1ps
`include "fcmp_defs.vh"

module mode_echo_lag #(
  parameter [`LAG_CNT_W-1:0] LAG_CYCLES = `ECHO_LAG_MS * `CLK_KHZ
) (
  input wire clk,
  input wire srst,
  input wire [3:0] mode_in,
  output reg [3:0] mode_echo_r
);

reg [`LAG_CNT_W-1:0] cnt_r;
reg [3:0] last_r;

////////////////////////////////////////////////////////////////////////
// restart the wait on any change, so a glitch never reaches the echo
always @(posedge clk) begin
  if (srst) begin
    cnt_r <= {`LAG_CNT_W{1'b0}};
    last_r <= `MODE_CMD;
    mode_echo_r <= `MODE_CMD;
  end else begin
    last_r <= mode_in;
    if (mode_in != last_r) begin
      cnt_r <= {`LAG_CNT_W{1'b0}};
    end else if (mode_echo_r != last_r) begin
      if (cnt_r >= LAG_CYCLES - 1'b1) begin
        mode_echo_r <= last_r; // copied unchanged
        cnt_r <= {`LAG_CNT_W{1'b0}};
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
end

endmodule

// [fcmp_check_asserts.sv]
// checker for the command/monitor port: handshake, monitor, echo, apb.
// assumes a bind onto the top module with the same echo lag.
`timescale 1ns/1ps
module fcmp_check #(
  parameter [23:0] ECHO_LAG_CYCLES = 24'd12
) (
  input wire clk,
  input wire srst,
  input wire [3:0] mode_select_in,
  input wire cmd_request,
  input wire [255:0] reply_words,
  input wire cmd_finish,
  input wire cmd_error,
  input wire [3:0] mode_select_echo,
  input wire [127:0] position_in,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // cycles the mode input has stood still
  reg [23:0] still_r;
  reg [3:0] prev_r;
  always @(posedge clk) begin
    prev_r <= mode_select_in;
    if (srst || mode_select_in != prev_r)
      still_r <= 24'h0;
    else if (still_r != 24'hffffff)
      still_r <= still_r + 24'h1;
  end
  // a request taken in command mode and held one more edge
  sequence s_taken;
    mode_select_in == 4'h0 && $rose(cmd_request) && !cmd_finish ##1
    mode_select_in == 4'h0 && cmd_request;
  endsequence
  property p_answer;
    s_taken |=> cmd_finish;
  endproperty
  a_answer: assert property (p_answer)
    else $error("finish late after request");
  property p_early;
    $rose(cmd_finish) |-> $past(cmd_request) && $past(cmd_request, 2);
  endproperty
  a_early: assert property (p_early)
    else $error("finish without held request");
  property p_err_rise;
    $rose(cmd_error) |-> $rose(cmd_finish);
  endproperty
  a_err_rise: assert property (p_err_rise)
    else $error("error rose apart from finish");
  property p_err_only;
    cmd_error |-> cmd_finish;
  endproperty
  a_err_only: assert property (p_err_only)
    else $error("error high without finish");
  property p_fin_drop;
    cmd_finish && !cmd_request |=> !cmd_finish;
  endproperty
  a_fin_drop: assert property (p_fin_drop)
    else $error("finish stayed after request fell");
  property p_err_fall;
    $fell(cmd_error) |-> $fell(cmd_finish);
  endproperty
  a_err_fall: assert property (p_err_fall)
    else $error("error fell apart from finish");
  property p_quiet;
    mode_select_in != 4'h0 |=> !cmd_finish && !cmd_error;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("handshake active in monitor mode");
  property p_live;
    mode_select_in == 4'h2 |=> reply_words[191:64] == $past(position_in);
  endproperty
  a_live: assert property (p_live)
    else $error("position monitor not refreshed");
  property p_echo;
    $changed(mode_select_echo) |->
      still_r >= ECHO_LAG_CYCLES - 24'd2 && mode_select_echo == prev_r;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo changed early or wrong");
  property p_unmapped;
    psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("no slave error on unmapped access");
endmodule

// [fb_master.sv]
// master station model: mode select, command words and request line.
// assumes the testbench calls its tasks from one process.
`timescale 1ns/1ps
module fb_master (
  input wire clk,
  input wire cmd_finish,
  input wire cmd_error,
  input wire [255:0] reply_words,
  output reg [3:0] mode_select_in = 4'h0,
  output reg cmd_request = 1'b0,
  output reg [255:0] command_words = 256'h0
);
  reg [255:0] reply_r;
  reg error_r;
  ////////////////////////////////////////
  // one full command exchange
  task automatic send(input [255:0] w);
    while ({cmd_request, cmd_finish, cmd_error} !== 3'b000) @(posedge clk);
    @(posedge clk);
    mode_select_in <= 4'h0;
    command_words <= w;
    @(posedge clk);
    cmd_request <= 1'b1;
    do @(posedge clk); while (cmd_finish !== 1'b1);
    reply_r = reply_words;
    error_r = cmd_error;
    cmd_request <= 1'b0;
    do @(posedge clk); while (cmd_finish !== 1'b0);
  endtask
  task automatic monitor(input [3:0] m, input [255:0] w);
    @(posedge clk);
    mode_select_in <= m;
    command_words <= w;
  endtask
  // stray request, only where a scenario asks for one
  task automatic raise(input r);
    @(posedge clk);
    cmd_request <= r;
  endtask
endmodule

// [testbench.sv]
// self-checking bench: apb registers, commands, monitor modes, echo.
// assumes the design header and the master model are compiled first.
`timescale 1ns/1ps
`include "fcmp_defs.vh"
module testbench;
  localparam [23:0] LAG = 24'd12;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [127:0] position_in = 128'h0;
  reg [15:0] torque_in = 16'h0;
  reg [7:0] paddr = 8'h0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  wire [3:0] mode_select_in, mode_select_echo;
  wire cmd_request, cmd_finish, cmd_error, pready, pslverr, irq;
  wire [255:0] command_words, reply_words;
  wire [31:0] prdata;
  integer seed = 17;
  integer bad_count = 0;
  integer checks_done = 0;
  integer i;
  reg [31:0] rd;
  reg se;
  reg [15:0] v, v2, arg;
  reg [15:0] codes [0:7] = '{`CMD_COUNT_WR, `CMD_COUNT_RD, `CMD_OVR_WR,
    `CMD_OVR_RD, `CMD_STATUS, `CMD_POSITION, `CMD_TORQUE, 16'h1234};
  ////////////////////////////////////////
  always #5 clk = ~clk;
  fieldbus_command_monitor_port #(.ECHO_LAG_CYCLES(LAG)) dut (
    .clk(clk), .srst(srst), .mode_select_in(mode_select_in),
    .cmd_request(cmd_request), .command_words(command_words),
    .reply_words(reply_words), .cmd_finish(cmd_finish),
    .cmd_error(cmd_error), .mode_select_echo(mode_select_echo),
    .position_in(position_in), .torque_in(torque_in), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  fb_master m (.clk(clk), .cmd_finish(cmd_finish), .cmd_error(cmd_error),
    .reply_words(reply_words), .mode_select_in(mode_select_in),
    .cmd_request(cmd_request), .command_words(command_words));
  // comparison and verdict
  task automatic chk(input string nm, input [127:0] e, input [127:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // error code a command should come back with
  function automatic [15:0] exp_err(input [15:0] c, input busy);
    if (busy)
      exp_err = `ERR_BUSY;
    else if (c == 16'h1234)
      exp_err = `ERR_ANALYSIS;
    else
      exp_err = `ERR_NONE;
  endfunction
  // watchdog against a hang
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    v = $random(seed);
    v2 = $random(seed);
    arg = {12'h0, 4'($random(seed))};
    position_in <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    torque_in <= $random(seed);
    apb(0, `A_CTRL, 0);
    chk("ctrl", 0, rd);
    apb(1, `A_STATUS_VAL, {16'h0, v});
    apb(0, 8'h40, 0);
    chk("slverr", 1, se);
    apb(1, `A_INT_EN, 32'h3);
    for (i = 0; i < 8; i++) begin
      m.send({208'h0, v2, codes[i] == `CMD_OVR_RD ? 16'h0 : arg, codes[i]});
      chk("code", codes[i], m.reply_r[15:0]);
      chk("errcode", exp_err(codes[i], 0), m.reply_r[63:48]);
      chk("errflag", codes[i] == 16'h1234, m.error_r);
      case (codes[i])
        `CMD_STATUS: chk("status", v, m.reply_r[47:32]);
        `CMD_COUNT_RD: chk("count", v2, m.reply_r[47:32]);
        `CMD_OVR_RD: chk("ovr", arg, m.reply_r[31:16]);
        `CMD_POSITION: chk("pos", position_in, m.reply_r[191:64]);
        `CMD_TORQUE: chk("torque", torque_in, m.reply_r[79:64]);
        default: ;
      endcase
    end
    @(posedge clk);
    chk("irq set", 1, irq);
    apb(0, `A_INT_STAT, 0);
    chk("stat", 3, rd[1:0]);
    apb(1, `A_INT_EN, 0);
    @(posedge clk);
    chk("irq masked", 0, irq);
    apb(1, `A_INT_CLR, 32'hf);
    apb(0, `A_INT_STAT, 0);
    chk("stat clr", 0, rd);
    apb(1, `A_CTRL, 1);
    m.send({240'h0, `CMD_STATUS});
    chk("busy", exp_err(0, 1), m.reply_r[63:48]);
    chk("busyflag", 1, m.error_r);
    apb(1, `A_CTRL, 0);
    m.monitor(4'h1, 0);
    m.raise(1);
    repeat (3) @(posedge clk);
    chk("ignored", 0, cmd_finish);
    m.raise(0);
    m.monitor(4'h2, 0);
    position_in <= ~position_in;
    repeat (3) @(posedge clk);
    chk("mon pos", position_in, reply_words[191:64]);
    m.monitor(4'h3, {224'h0, arg, `SUB_ARBITRARY});
    repeat (3) @(posedge clk);
    chk("sub arb", v2, reply_words[47:32]);
    m.monitor(4'h3, {224'h0, arg, `SUB_SEQUENCE});
    repeat (3) @(posedge clk);
    chk("sub seq", v2, reply_words[47:32]);
    m.monitor(4'h3, {240'h0, 16'h0002});
    repeat (3) @(posedge clk);
    chk("sub bad", `ERR_ANALYSIS, reply_words[63:48]);
    m.monitor(4'h4, 0);
    repeat (3) @(posedge clk);
    chk("mon torque", torque_in, reply_words[79:64]);
    m.monitor(4'h5, 0);
    repeat (3) @(posedge clk);
    chk("rsvd", 0, |reply_words);
    chk("echo early", 0, mode_select_echo);
    repeat (LAG + 6) @(posedge clk);
    chk("echo", 5, mode_select_echo);
    // busy command, echo change and reserved mode all since the clear
    apb(0, `A_INT_STAT, 0);
    chk("stat all", 4'hf, rd);
    apb(0, `A_LAST_CMD, 0);
    chk("last cmd", `CMD_STATUS, rd);
    give_verdict;
  end
endmodule
bind fieldbus_command_monitor_port fcmp_check #(
  .ECHO_LAG_CYCLES(ECHO_LAG_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .mode_select_in(mode_select_in),
  .cmd_request(cmd_request), .reply_words(reply_words),
  .cmd_finish(cmd_finish), .cmd_error(cmd_error),
  .mode_select_echo(mode_select_echo), .position_in(position_in),
  .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr));
